/* File: rtl/cbts_bit_timing.sv */
`timescale 1ns/1ps
// Functional notes
// RQ1: quantum is input clock divided by six-bit prescaler value plus one.
// RQ2: resynchronize on relevant recessive-to-dominant bus edges while enabled.
// RQ3: jump width field bits 6-5 gives maximum adjustment of value plus one.
// RQ4: resync may lengthen or shorten a bit by at most the jump width.
// RQ5: propagation field bits 3-1 gives segment of value plus one quanta.
// RQ6: software sizes propagation segment to twice the loop delays.
// RQ7: phase two field bits 6-4 gives segment of value plus one quanta.
// RQ8: early edge shortens phase two by up to the jump width.
// RQ9: phase one field bits 3-1 gives segment of value plus one quanta.
// RQ10: late edge lengthens phase one by up to the jump width.
// RQ11: software keeps phase two at least phase one and two quanta.
// RQ12: sample-type bit clear takes one sample at the sample point.
// RQ13: sample-type bit set takes three samples half a quantum apart; with prescaler zero the code takes them one quantum apart.
// RQ14: triple sampling result is the majority of the three samples.
// RQ15: software touches timing registers only while controller is disabled.
// RQ16: reserved bits read indeterminate and are never written as one.
// RQ17: timing registers are not initialised by reset.
// RQ18: bit is sync, propagation, phase one, phase two; sample ends phase one.
// RQ19: each adjustment is the lesser of phase error and jump width.
module cbts_bit_timing (
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               reset,
	// special-function register bus
	input  wire cbts_pkg::cbts_sfr_s sfr,
	output logic [7:0]              sfr_rdata_q,
	// controller enable from the general control register
	input  wire logic               controller_enable_bit,
	// can bus receive line, synchronous to mclk
	input  wire logic               can_rx,
	// bit timing results
	output logic                    rx_bit_q,
	output logic                    sample_q,
	output logic                    bit_start_q
);
	logic [7:0]            prescale_q;
	logic [7:0]            jump_prop_q;
	logic [7:0]            phase_samp_q;
	cbts_pkg::cbts_cfg_s   cfg;
	cbts_pkg::cbts_state_e state_q;
	logic                  tq_tick;
	logic                  half_tick;
	logic [3:0]            seg_cnt_q;
	logic [3:0]            ext_q;
	logic [3:0]            cut_q;
	logic                  resynced_q;
	logic                  rx_q;
	logic                  edge_pend_q;
	logic [1:0]            hist_q;
	logic [3:0]            jump_len;
	logic [3:0]            prop_len;
	logic [3:0]            ph1_len;
	logic [3:0]            ph2_len;
	logic                  edge_now;
	logic                  edge_take;
	logic [3:0]            ext_now;
	logic [3:0]            cut_now;
	logic [3:0]            seg_next;
	logic                  ph1_done;
	logic                  ph2_done;
	logic                  vote;

	function automatic logic [3:0] cbts_min4(input logic [3:0] a,
		input logic [3:0] b);
		return (a < b) ? a : b;
	endfunction

	// timing registers: no reset, content undefined until programmed
	always_ff @(posedge mclk) begin
		if (sfr.wr && sfr.addr == cbts_pkg::ADDR_PRESCALE) begin
			prescale_q <= sfr.wdata & cbts_pkg::MASK_PRESCALE;  // [RQ17] [RQ16]
		end
		if (sfr.wr && sfr.addr == cbts_pkg::ADDR_JUMP_PROP) begin
			jump_prop_q <= sfr.wdata & cbts_pkg::MASK_JUMP_PROP; // [RQ17] [RQ16]
		end
		if (sfr.wr && sfr.addr == cbts_pkg::ADDR_PHASE_SAMP) begin
			phase_samp_q <= sfr.wdata & cbts_pkg::MASK_PHASE_SAMP; // [RQ17] [RQ16]
		end
	end

	// read data held until the next read
	always_ff @(posedge mclk) begin
		if (reset) begin
			sfr_rdata_q <= cbts_pkg::RDATA_RESET;
		end else if (sfr.rd) begin
			case (sfr.addr)
				cbts_pkg::ADDR_PRESCALE:  sfr_rdata_q <= prescale_q;
				cbts_pkg::ADDR_JUMP_PROP: sfr_rdata_q <= jump_prop_q;
				cbts_pkg::ADDR_PHASE_SAMP: sfr_rdata_q <= phase_samp_q;
				default:                  sfr_rdata_q <= cbts_pkg::RDATA_RESET;
			endcase
		end
	end

	always_comb begin
		cfg.prescaler_field           = prescale_q[cbts_pkg::PSC_LSB +: 6];
		cfg.jump_width_field          = jump_prop_q[cbts_pkg::JUMP_LSB +: 2];
		cfg.propagation_segment_field = jump_prop_q[cbts_pkg::PROP_LSB +: 3];
		cfg.phase_two_field           = phase_samp_q[cbts_pkg::PH2_LSB +: 3];
		cfg.phase_one_field           = phase_samp_q[cbts_pkg::PH1_LSB +: 3];
		cfg.sample_type_bit           = phase_samp_q[cbts_pkg::STYPE_POS];
	end

	assign jump_len = {2'b00, cfg.jump_width_field} + 4'h1;           // [RQ3]
	assign prop_len = {1'b0, cfg.propagation_segment_field} + 4'h1;  // [RQ5]
	assign ph1_len  = {1'b0, cfg.phase_one_field} + 4'h1;            // [RQ9]
	assign ph2_len  = {1'b0, cfg.phase_two_field} + 4'h1;            // [RQ7]

	cbts_prescaler u_prescaler (
		.mclk            (mclk),
		.reset           (reset),
		.run             (controller_enable_bit),
		.prescaler_field (cfg.prescaler_field), // [RQ1]
		.tq_tick         (tq_tick),
		.half_tick       (half_tick)
	);

	// only an edge after a recessive bit counts, one per bit
	assign edge_now  = controller_enable_bit && rx_q && !can_rx
		&& rx_bit_q && !resynced_q;                                   // [RQ2]
	assign edge_take = tq_tick && (edge_pend_q || edge_now);
	assign seg_next  = seg_cnt_q + 4'h1;

	// phase error measured in quanta, clipped to the jump width
	always_comb begin
		ext_now = ext_q;
		cut_now = cut_q;
		if (edge_take && state_q == cbts_pkg::ST_PROP) begin
			ext_now = cbts_min4(seg_next, jump_len);                  // [RQ10] [RQ19]
		end else if (edge_take && state_q == cbts_pkg::ST_PH1) begin
			ext_now = cbts_min4(prop_len + seg_next, jump_len);       // [RQ10] [RQ19]
		end else if (edge_take && state_q == cbts_pkg::ST_PH2) begin
			cut_now = cbts_min4(ph2_len - seg_cnt_q, jump_len);       // [RQ8] [RQ19]
		end
	end

	assign ph1_done = (seg_next >= ph1_len + ext_now);               // [RQ4]
	assign ph2_done = (seg_next >= ph2_len - cut_now);               // [RQ4]

	always_ff @(posedge mclk) begin
		if (reset) begin
			rx_q        <= 1'b1;
			edge_pend_q <= 1'b0;
		end else begin
			rx_q        <= can_rx;
			// a new edge on the tick itself is taken through edge_take; the pending flag clears
			edge_pend_q <= (edge_pend_q && !tq_tick) ||
				(edge_now && !tq_tick);                               // [RQ2]
		end
	end

	// bit segment sequencer
	always_ff @(posedge mclk) begin
		if (reset || !controller_enable_bit) begin
			state_q    <= cbts_pkg::ST_SYNC;
			seg_cnt_q  <= cbts_pkg::COUNT_RESET;
			ext_q      <= cbts_pkg::COUNT_RESET;
			cut_q      <= cbts_pkg::COUNT_RESET;
			resynced_q <= 1'b0;
		end else if (tq_tick) begin
			ext_q     <= ext_now;
			cut_q     <= cut_now;
			seg_cnt_q <= seg_next;
			if (edge_take && state_q != cbts_pkg::ST_SYNC) begin
				resynced_q <= 1'b1;                                   // [RQ2]
			end
			case (state_q)
				cbts_pkg::ST_SYNC: begin
					if (seg_next >= cbts_pkg::SYNC_LEN_TQ) begin      // [RQ18]
						state_q   <= cbts_pkg::ST_PROP;
						seg_cnt_q <= cbts_pkg::COUNT_RESET;
					end
				end
				cbts_pkg::ST_PROP: begin
					if (seg_next >= prop_len) begin                   // [RQ5]
						state_q   <= cbts_pkg::ST_PH1;
						seg_cnt_q <= cbts_pkg::COUNT_RESET;
					end
				end
				cbts_pkg::ST_PH1: begin
					if (ph1_done) begin                               // [RQ18] [RQ10]
						state_q   <= cbts_pkg::ST_PH2;
						seg_cnt_q <= cbts_pkg::COUNT_RESET;
					end
				end
				cbts_pkg::ST_PH2: begin
					if (ph2_done) begin                               // [RQ8]
						state_q    <= cbts_pkg::ST_SYNC;
						seg_cnt_q  <= cbts_pkg::COUNT_RESET;
						ext_q      <= cbts_pkg::COUNT_RESET;
						cut_q      <= cbts_pkg::COUNT_RESET;
						resynced_q <= 1'b0;
					end
				end
				default: begin
					state_q   <= cbts_pkg::ST_SYNC;
					seg_cnt_q <= cbts_pkg::COUNT_RESET;
				end
			endcase
		end
	end

	// two earlier samples before the sample point, half a quantum apart, or one quantum apart with prescaler zero
	always_ff @(posedge mclk) begin
		if (reset) begin
			hist_q <= 2'b11;
		end else if (half_tick || tq_tick) begin
			hist_q <= {hist_q[0], can_rx};                            // [RQ13]
		end
	end

	assign vote = (hist_q[1] & hist_q[0]) | (hist_q[1] & can_rx) |
		(hist_q[0] & can_rx);                                         // [RQ14]

	always_ff @(posedge mclk) begin
		if (reset) begin
			rx_bit_q    <= 1'b1;
			sample_q    <= 1'b0;
			bit_start_q <= 1'b0;
		end else begin
			sample_q    <= 1'b0;
			bit_start_q <= tq_tick && state_q == cbts_pkg::ST_PH2 && ph2_done;
			if (tq_tick && state_q == cbts_pkg::ST_PH1 && ph1_done) begin
				sample_q <= 1'b1;                                     // [RQ18]
				// limitation: with prescaler zero the three samples are one quantum apart
				rx_bit_q <= cfg.sample_type_bit ? vote : can_rx;      // [RQ12] [RQ13]
			end
		end
	end

	AST_SYNC_ONE_TQ: assert property (@(posedge mclk) disable iff (reset) // [RQ18]
		(tq_tick && controller_enable_bit && state_q == cbts_pkg::ST_SYNC)
		|=> state_q == cbts_pkg::ST_PROP)
		else $error("sync segment not one quantum");
	AST_PROP_LEN: assert property (@(posedge mclk) disable iff (reset) // [RQ5]
		(tq_tick && controller_enable_bit && state_q == cbts_pkg::ST_PROP
		&& seg_cnt_q < prop_len - 4'h1) |=> state_q == cbts_pkg::ST_PROP)
		else $error("propagation segment ended early");
	AST_EXT_LIMIT: assert property (@(posedge mclk) disable iff (reset) // [RQ10]
		controller_enable_bit |-> ext_q <= jump_len)
		else $error("phase one lengthened beyond jump width");
	AST_CUT_LIMIT: assert property (@(posedge mclk) disable iff (reset) // [RQ8]
		controller_enable_bit |-> cut_q <= jump_len)
		else $error("phase two shortened beyond jump width");
	AST_PH1_SAMPLE: assert property (@(posedge mclk) disable iff (reset) // [RQ18]
		sample_q |-> $past(state_q) == cbts_pkg::ST_PH1
		&& state_q == cbts_pkg::ST_PH2)
		else $error("sample not at end of phase one");
	AST_SINGLE: assert property (@(posedge mclk) disable iff (reset) // [RQ12]
		(sample_q && !$past(cfg.sample_type_bit)) |-> rx_bit_q == $past(can_rx))
		else $error("single sample value wrong");
	AST_MAJORITY: assert property (@(posedge mclk) disable iff (reset) // [RQ14]
		(sample_q && $past(cfg.sample_type_bit)) |-> rx_bit_q == $past(vote))
		else $error("majority sample value wrong");
	AST_RSV_ZERO: assert property (@(posedge mclk) disable iff (reset) // [RQ16]
		(sfr.rd && sfr.addr == cbts_pkg::ADDR_JUMP_PROP)
		|=> (sfr_rdata_q & ~cbts_pkg::MASK_JUMP_PROP) == 8'h00)
		else $error("reserved bits read non-zero");
	AST_DISABLED_IDLE: assert property (@(posedge mclk) disable iff (reset) // [RQ2]
		!controller_enable_bit |=> state_q == cbts_pkg::ST_SYNC && !sample_q)
		else $error("timing ran while disabled");

endmodule

/* File: rtl/cbts_pkg.sv */
package cbts_pkg;

	// register addresses on the special-function register bus
	localparam logic [7:0] ADDR_PRESCALE  = 8'hB4;
	localparam logic [7:0] ADDR_JUMP_PROP = 8'hB5;
	localparam logic [7:0] ADDR_PHASE_SAMP = 8'hB6;

	// field positions
	localparam int PSC_LSB   = 1;
	localparam int JUMP_LSB  = 5;
	localparam int PROP_LSB  = 1;
	localparam int PH2_LSB   = 4;
	localparam int PH1_LSB   = 1;
	localparam int STYPE_POS = 0;

	// writable bits; reserved bits are never stored and read as zero
	localparam logic [7:0] MASK_PRESCALE  = 8'h7E;
	localparam logic [7:0] MASK_JUMP_PROP = 8'h6E;
	localparam logic [7:0] MASK_PHASE_SAMP = 8'h7F;

	// reset values
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [3:0] COUNT_RESET = 4'h0;

	// timing: sync segment is one quantum
	localparam logic [3:0] SYNC_LEN_TQ = 4'h1;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cbts_sfr_s;

	typedef struct packed {
		logic [5:0] prescaler_field;
		logic [1:0] jump_width_field;
		logic [2:0] propagation_segment_field;
		logic [2:0] phase_two_field;
		logic [2:0] phase_one_field;
		logic       sample_type_bit;
	} cbts_cfg_s;

	typedef enum logic [3:0] {
		ST_SYNC = 4'h1,
		ST_PROP = 4'h2,
		ST_PH1  = 4'h4,
		ST_PH2  = 4'h8
	} cbts_state_e;

endpackage

/* File: rtl/cbts_prescaler.sv */
`timescale 1ns/1ps
module cbts_prescaler (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset,
	// control
	input  wire logic       run,
	input  wire logic [5:0] prescaler_field,
	// quantum ticks
	output logic            tq_tick,
	output logic            half_tick
);
	logic [5:0] cnt_q;
	logic [5:0] half_pt;

	assign half_pt   = prescaler_field >> 1;
	assign tq_tick   = run && (cnt_q == prescaler_field);          // [RQ1]
	assign half_tick = run && (cnt_q == half_pt) && !tq_tick;      // [RQ13]

	// one quantum is prescaler value plus one mclk periods
	always_ff @(posedge mclk) begin
		if (reset || !run || tq_tick) begin
			cnt_q <= 6'h00;                                        // [RQ1]
		end else begin
			cnt_q <= cnt_q + 6'h01;
		end
	end

	AST_TQ_AFTER_COUNT: assert property (@(posedge mclk) disable iff (reset) // [RQ1]
		tq_tick |-> ##1 (cnt_q == 6'h00))
		else $error("quantum counter did not wrap");
	AST_TQ_SPACING: assert property (@(posedge mclk) disable iff (reset) // [RQ1]
		(tq_tick && $stable(prescaler_field) && prescaler_field == 6'h01)
		|=> !tq_tick ##1 (tq_tick || !run))
		else $error("quantum period wrong");

endmodule

/* File: verification/cbts_bus_node.sv */
`timescale 1ns/1ps
module cbts_bus_node (
	// other node drive request, high drives dominant
	input  wire logic dom_req,
	// bus level as the block receives it
	output logic      can_rx
);
	// wired-and bus; pull-up leaves it recessive when nobody drives
	assign can_rx = ~dom_req;
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
	logic                mclk = 1'b0;
	logic                reset = 1'b1;
	cbts_pkg::cbts_sfr_s sfr = '0;
	logic                en = 1'b0;
	logic                dom = 1'b0;
	logic                can_rx;
	logic [7:0]          rdata;
	logic                rx_bit;
	logic                smp_p;
	logic                bit_p;
	int                  failures = 0;
	int                  n_compared = 0;
	int                  n;
	logic [7:0]          addrs [4] = '{8'hB4, 8'hB5, 8'hB6, 8'hB7};
	logic [7:0]          full [4] = '{8'h7E, 8'h6E, 8'h7F, 8'hA5};

	always #4 mclk = ~mclk;

	cbts_bus_node cbts_bus_node_i (.dom_req(dom), .can_rx(can_rx));
	cbts_bit_timing cbts_bit_timing_i (
		.mclk                 (mclk),
		.reset                (reset),
		.sfr                  (sfr),
		.sfr_rdata_q          (rdata),
		.controller_enable_bit(en),
		.can_rx               (can_rx),
		.rx_bit_q             (rx_bit),
		.sample_q             (smp_p),
		.bit_start_q          (bit_p)
	);

	task test_done;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk_val(input logic [7:0] got, input logic [7:0] exp,
			input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask

	task chk_cnt(input int got, input int exp, input string what);
		n_compared++;
		if (got != exp) begin
			failures++;
			$display("mismatch at %0t: %s %0d not %0d", $time, what, got, exp);
		end
	endtask

	task reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		sfr.wr <= 1'b0;
	endtask

	task reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		sfr <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		sfr.rd <= 1'b0;
		@(posedge mclk);
		#1 d = rdata;
	endtask

	// reprogramming only with the controller stopped
	task prog_regs(input int psc, jw, pseg, ph2, ph1, stype);
		@(posedge mclk);
		en <= 1'b0;
		// callers keep phase two >= phase one and >= 2 quanta
		reg_wr(8'hB4, {1'b0, 6'(psc), 1'b0});
		reg_wr(8'hB5, {1'b0, 2'(jw), 1'b0, 3'(pseg), 1'b0});
		reg_wr(8'hB6, {1'b0, 3'(ph2), 3'(ph1), 1'(stype)});
		@(posedge mclk);
		en <= 1'b1;
	endtask

	// bounded wait for bit start (which=1) or sample pulse (which=0)
	task wait_p(input bit which, output int c);
		c = 0;
		do begin
			@(posedge mclk);
			#1 c++;
		end while ((which ? bit_p : smp_p) !== 1'b1 && c < 2000);
	endtask

	task test_regs;
		logic [7:0] d;
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 4; i++)
				reg_wr(addrs[i], p ? 8'h00 : full[i]);
			for (int i = 0; i < 4; i++) begin
				reg_rd(addrs[i], d);
				chk_val(d, (p || i == 3) ? 8'h00 : full[i], "readback");
			end
		end
	endtask

	task test_timing(input int psc, pseg, ph1, ph2);
		prog_regs(psc, 0, pseg, ph2, ph1, 0);
		wait_p(1, n);
		wait_p(0, n);
		chk_cnt(n, (3 + pseg + ph1) * (psc + 1), "to sample");
		wait_p(1, n);
		chk_cnt(n, (ph2 + 1) * (psc + 1), "phase two");
		wait_p(1, n);
		chk_cnt(n, (4 + pseg + ph1 + ph2) * (psc + 1), "bit");
	endtask

	// nominal bit 11 quanta; edge seen in quantum s of the bit
	task test_resync(input int jw, s, exp);
		prog_regs(0, jw, 1, 3, 3, 0);
		wait_p(1, n);
		wait_p(1, n);
		n = 0;
		do begin
			@(posedge mclk);
			if (n + 1 == s - 1)
				dom <= 1'b1;
			#1 n++;
		end while (bit_p !== 1'b1 && n < 100);
		chk_cnt(n, exp, "resync bit");
		@(posedge mclk);
		dom <= 1'b0;
	endtask

	task test_sampling;
		logic seen;
		seen = 1'b0;
		for (int stype = 0; stype < 2; stype++) begin
			prog_regs(0, 0, 0, 1, 0, stype);
			dom <= 1'b1;
			repeat (3) wait_p(1, n);
			chk_val({7'h00, rx_bit}, 8'h00, "dominant");
			@(posedge mclk);
			dom <= 1'b0;
			repeat (3) wait_p(1, n);
			chk_val({7'h00, rx_bit}, 8'h01, "recessive");
		end
		// recessive glitch in dominant bits: no resync edge follows it,
		// so only the majority can hide it at the sample point
		@(posedge mclk);
		dom <= 1'b1;
		repeat (3) wait_p(1, n);
		for (int off = 0; off < 5; off++) begin
			wait_p(1, n);
			repeat (off) @(posedge mclk);
			@(posedge mclk);
			dom <= 1'b0;
			@(posedge mclk);
			dom <= 1'b1;
			repeat (12) begin
				@(posedge mclk);
				#1 if (rx_bit !== 1'b0) seen = 1'b1;
			end
		end
		chk_val({7'h00, seen}, 8'h00, "glitch");
		@(posedge mclk);
		dom <= 1'b0;
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		test_regs;
		test_timing(1, 2, 1, 2);
		test_timing(0, 7, 7, 7);
		test_timing(63, 0, 0, 1);
		test_resync(0, 3, 12);
		test_resync(3, 3, 13);
		test_resync(1, 5, 13);
		test_resync(3, 7, 15);
		test_resync(0, 9, 10);
		test_resync(1, 9, 9);
		test_sampling;
		test_done;
	end

	// whole run needs well under 10000 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		$display("mismatch at %0t: watchdog expired", $time);
		test_done;
	end
endmodule
